// File: common/smsp_pkg.sv
// constants for the switch monitor serial port
// assumes one 20 mhz clock; all pins arrive asynchronous to it
//
// Notes on behaviour
// - select fall enables output, captures alert, switches
// - select rise floats the serial output
// - select rise releases alert unless change during select
// - command applied only at select rise
// - select fall wakes from sleep; data may be stale; code also needs logic supply
// - serial input sampled on falling serial clock
// - output bit changes on rising serial clock
// - deselected device ignores clock, input; output floats
// - complete word is 24 bits; ones stored
// - open switch reads zero, closed reads one
// - first rising edge shows bit 23, then lower
// - one shared shift path, msb first both ways
// - enabled input change drives alert low in normal
// - alert flag captured at select fall, own only
// - sleep, wake high: alert fall wakes device; code also needs logic supply
// - wake line low in normal, released in sleep
// - wake fall wakes; needs alert high with logic supply
// - dual inputs closed per battery/ground polarity setting
// - ground inputs closed below threshold
// - battery supply application resets device
// - every response carries status, alert, temperature flags
// - power-on reset enters normal mode
package smsp_pkg;
    // ************************************************************
    // word layout
    // ************************************************************
    localparam int         WORD_W        = 24;
    localparam int         CMD_W         = 8;
    localparam int         CMD_POS       = 16;
    localparam int         ALERT_POS     = 23;
    localparam int         TEMP_POS      = 22;
    localparam int         GND_POS       = 8;
    // ************************************************************
    // command codes and reset values
    // ************************************************************
    localparam logic [7:0] CMD_SETTINGS  = 8'h01;
    localparam logic [7:0] CMD_WAKE_DUAL = 8'h02;
    localparam logic [7:0] CMD_WAKE_GND  = 8'h03;
    localparam logic [7:0] CMD_SLEEP     = 8'h05;
    localparam logic [7:0] CMD_RESET     = 8'h7f;
    localparam logic [7:0] RST_POLARITY  = 8'hff;
    localparam logic [7:0] RST_EN_DUAL   = 8'hff;
    localparam logic [13:0] RST_EN_GND   = 14'h3fff;
    localparam logic [4:0] RST_BITCNT    = 5'h00;
    typedef enum logic {SMSP_NORMAL = 1'b0, SMSP_SLEEP = 1'b1} smsp_mode_e;
endpackage

// File: rtl/smsp_core.sv
// serial slave port, alert and wake logic of the switch monitor
// assumes comparator outputs and link pins are asynchronous to mclk
`timescale 1ns/100ps
module smsp_core #(
    parameter int DUAL_N = 8,
    parameter int GND_N  = 14
) (
    // clock and reset
    input  wire logic              mclk,
    input  wire logic              srst,
    // supplies and comparators
    input  wire logic              battery_supply,
    input  wire logic              logic_supply,
    input  wire logic              over_temp,
    input  wire logic [DUAL_N-1:0] dual_polarity_inputs,
    input  wire logic [GND_N-1:0]  ground_only_inputs,
    // serial link
    input  wire logic              cs_n,
    input  wire logic              sclk,
    input  wire logic              sdi,
    output logic                   sdo,
    output logic                   sdo_oe_n,
    // alert open drain
    input  wire logic              alert_n_in,
    output logic                   alert_n_out,
    output logic                   alert_oe_n,
    // wake open drain and stale status flag
    input  wire logic              wake_n_in,
    output logic                   wake_n_out,
    output logic                   wake_oe_n,
    output logic                   stale_status
);
    localparam int LINK_W = 5;
    localparam int SUP_W  = 3;
    localparam int SW_W   = DUAL_N + GND_N;
    // ************************************************************
    // synchronisers
    // ************************************************************
    // two flops per pin; only the second stage is read
    logic [LINK_W-1:0] link_s1_ff;
    logic [LINK_W-1:0] link_s2_ff;
    logic [SUP_W-1:0]  sup_s1_ff;
    logic [SUP_W-1:0]  sup_s2_ff;
    logic [SW_W-1:0]   sw_s1_ff;
    logic [SW_W-1:0]   sw_s2_ff;
    always_ff @(posedge mclk)
    begin
        link_s1_ff <= {cs_n, sclk, sdi, alert_n_in, wake_n_in};
        link_s2_ff <= link_s1_ff;
    end
    always_ff @(posedge mclk)
    begin
        sup_s1_ff <= {battery_supply, logic_supply, over_temp};
        sup_s2_ff <= sup_s1_ff;
    end
    always_ff @(posedge mclk)
    begin
        sw_s1_ff <= {dual_polarity_inputs, ground_only_inputs};
        sw_s2_ff <= sw_s1_ff;
    end
    logic              cs_s;
    logic              sclk_s;
    logic              sdi_s;
    logic              alrt_s;
    logic              wake_s;
    logic              bat_s;
    logic              lsup_s;
    logic              otemp_s;
    logic [DUAL_N-1:0] dual_s;
    logic [GND_N-1:0]  gnd_s;
    assign {cs_s, sclk_s, sdi_s, alrt_s, wake_s} = link_s2_ff;
    assign {bat_s, lsup_s, otemp_s}              = sup_s2_ff;
    assign {dual_s, gnd_s}                       = sw_s2_ff;

    // ************************************************************
    // edge detection
    // ************************************************************
    // delayed copies fill with idle levels during the reset hold
    logic cs_d_ff;
    logic sclk_d_ff;
    logic alrt_d_ff;
    logic wake_d_ff;
    logic bat_d_ff;
    always_ff @(posedge mclk)
    begin
        cs_d_ff   <= cs_s;
        sclk_d_ff <= sclk_s;
        alrt_d_ff <= alrt_s;
        wake_d_ff <= wake_s;
        bat_d_ff  <= bat_s;
    end
    logic cs_fall;
    logic cs_rise;
    logic sel;
    logic sck_rise;
    logic sck_fall;
    logic alrt_fall;
    logic wake_fall;
    logic por;
    assign cs_fall   = cs_d_ff & ~cs_s;
    assign cs_rise   = ~cs_d_ff & cs_s;
    assign sel       = ~cs_s & ~cs_d_ff;
    assign sck_rise  = sel & ~sclk_d_ff & sclk_s;
    assign sck_fall  = sel & sclk_d_ff & ~sclk_s;
    assign alrt_fall = alrt_d_ff & ~alrt_s;
    assign wake_fall = wake_d_ff & ~wake_s;
    assign por       = srst | (~bat_d_ff & bat_s);

    // ************************************************************
    // configuration and switch state
    // ************************************************************
    logic [DUAL_N-1:0] polarity_ff;
    logic [DUAL_N-1:0] en_dual_ff;
    logic [GND_N-1:0]  en_gnd_ff;
    smsp_pkg::smsp_mode_e mode_ff;
    logic [DUAL_N+GND_N-1:0] closed;
    logic [DUAL_N+GND_N-1:0] closed_d_ff;
    logic [DUAL_N+GND_N-1:0] en_all;
    // comparator high means above threshold
    assign closed = {~(dual_s ^ polarity_ff), ~gnd_s};
    assign en_all = {en_dual_ff, en_gnd_ff};
    wire   change = |((closed ^ closed_d_ff) & en_all);
    always_ff @(posedge mclk)
    begin
        closed_d_ff <= closed;
    end

    // ************************************************************
    // shift path
    // ************************************************************
    logic [smsp_pkg::WORD_W-1:0] shreg_ff;
    logic [4:0]                  bitcnt_ff;
    logic                        alert_ff;
    logic                        pend_ff;
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            shreg_ff  <= '0;
            bitcnt_ff <= smsp_pkg::RST_BITCNT;
        end
        else if (cs_fall)
        begin
            shreg_ff <= '0;
            shreg_ff[smsp_pkg::ALERT_POS] <= alert_ff;
            shreg_ff[smsp_pkg::TEMP_POS]  <= otemp_s;
            shreg_ff[DUAL_N+GND_N-1:0]    <= closed;
            bitcnt_ff <= smsp_pkg::RST_BITCNT;
        end
        else if (sck_fall)
        begin
            shreg_ff  <= {shreg_ff[smsp_pkg::WORD_W-2:0], sdi_s};
            if (bitcnt_ff != 5'h1f)
                bitcnt_ff <= bitcnt_ff + 5'h01;
        end
    end
    // rule 9: only exactly 24 bits counts as complete
    wire full_word = (bitcnt_ff == 5'(smsp_pkg::WORD_W));
    wire [7:0] code = shreg_ff[smsp_pkg::CMD_POS +: smsp_pkg::CMD_W];
    wire apply = cs_rise & full_word & (mode_ff == smsp_pkg::SMSP_NORMAL);

    always_ff @(posedge mclk)
    begin
        if (por)
        begin
            polarity_ff <= smsp_pkg::RST_POLARITY;
            en_dual_ff  <= smsp_pkg::RST_EN_DUAL;
            en_gnd_ff   <= smsp_pkg::RST_EN_GND;
        end
        else if (apply)
        begin
            case (code)
                smsp_pkg::CMD_SETTINGS:  polarity_ff <= shreg_ff[DUAL_N-1:0];
                smsp_pkg::CMD_WAKE_DUAL: en_dual_ff  <= shreg_ff[DUAL_N-1:0];
                smsp_pkg::CMD_WAKE_GND:  en_gnd_ff   <= shreg_ff[GND_N-1:0];
                smsp_pkg::CMD_RESET:
                begin
                    polarity_ff <= smsp_pkg::RST_POLARITY;
                    en_dual_ff  <= smsp_pkg::RST_EN_DUAL;
                    en_gnd_ff   <= smsp_pkg::RST_EN_GND;
                end
                default: ;
            endcase
        end
    end

    // ************************************************************
    // mode
    // ************************************************************
    logic wake_by_cs;
    logic wake_by_alert;
    logic wake_by_pin;
    logic wake_by_switch;
    // without the logic supply select and alert cannot wake
    assign wake_by_cs     = cs_fall & lsup_s;
    assign wake_by_alert  = alrt_fall & wake_s & lsup_s;
    assign wake_by_pin    = wake_fall & (alrt_s | ~lsup_s);
    assign wake_by_switch = change;
    always_ff @(posedge mclk)
    begin
        if (por)
            mode_ff <= smsp_pkg::SMSP_NORMAL;
        else if (mode_ff == smsp_pkg::SMSP_SLEEP)
        begin
            if (wake_by_cs | wake_by_alert | wake_by_pin | wake_by_switch)
                mode_ff <= smsp_pkg::SMSP_NORMAL;
        end
        else if (apply & (code == smsp_pkg::CMD_SLEEP))
            mode_ff <= smsp_pkg::SMSP_SLEEP;
    end

    // ************************************************************
    // alert
    // ************************************************************
    always_ff @(posedge mclk)
    begin
        if (por)
        begin
            alert_ff <= 1'b0;
            pend_ff  <= 1'b0;
        end
        else
        begin
            // set wins over clear at select rise
            if (change & (mode_ff == smsp_pkg::SMSP_NORMAL))
                alert_ff <= 1'b1;
            else if (cs_rise & ~pend_ff)
                alert_ff <= 1'b0;
            if (cs_rise)
                pend_ff <= 1'b0;
            else if (sel & change)
                pend_ff <= 1'b1;
        end
    end

    // ************************************************************
    // pin drivers
    // ************************************************************
    always_ff @(posedge mclk)
    begin
        if (srst)
            sdo_oe_n <= 1'b1;
        else if (cs_fall)
            sdo_oe_n <= 1'b0;
        else if (cs_rise | cs_s)
            sdo_oe_n <= 1'b1;
    end
    always_ff @(posedge mclk)
    begin
        if (srst)
            sdo <= 1'b0;
        else if (sck_rise)
            sdo <= shreg_ff[smsp_pkg::WORD_W-1];
    end
    // open drain: data held low, only the enable moves
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            alert_n_out <= 1'b0;
            alert_oe_n  <= 1'b1;
        end
        else
        begin
            alert_n_out <= 1'b0;
            alert_oe_n  <= ~alert_ff;
        end
    end
    // wake pulled low while awake
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            wake_n_out <= 1'b0;
            wake_oe_n  <= 1'b0;
        end
        else
        begin
            wake_n_out <= 1'b0;
            wake_oe_n  <= (mode_ff == smsp_pkg::SMSP_SLEEP);
        end
    end
    // status of a waking transfer may be stale
    logic stale_ff;
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            stale_ff     <= 1'b0;
            stale_status <= 1'b0;
        end
        else
        begin
            if (cs_fall)
                stale_ff <= (mode_ff == smsp_pkg::SMSP_SLEEP);
            stale_status <= stale_ff;
        end
    end
endmodule

// File: bench/smsp_props.sv
// checker of the switch monitor link pins
// assumes a bind onto smsp_core, lines resolved by the bench
`timescale 1ns/100ps
module smsp_props #(parameter int GND_N = 14) (
    // watched pins
    input wire logic             mclk,
    input wire logic             srst,
    input wire logic             cs_n,
    input wire logic             sclk,
    input wire logic             sdo,
    input wire logic             sdo_oe_n,
    input wire logic             alert_n_in,
    input wire logic             alert_oe_n,
    input wire logic             wake_n_in,
    input wire logic             wake_oe_n,
    input wire logic [GND_N-1:0] ground_only_inputs
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    // ****
    // pin relations, bounds allow for the 2-ff sync
    // ****
    property p_oe_on; $fell(cs_n) |-> ##[2:7] !sdo_oe_n; endproperty
    a_oe_on: assert property (p_oe_on) else $error("sdo not enabled");
    property p_oe_off; $rose(cs_n) |-> ##[2:7] sdo_oe_n; endproperty
    a_oe_off: assert property (p_oe_off) else $error("sdo not floated");
    property p_float; cs_n[*8] |-> sdo_oe_n; endproperty
    a_float: assert property (p_float) else $error("sdo driven while idle");
    property p_hold; (!sclk && !sdo_oe_n)[*8] |-> $stable(sdo); endproperty
    a_hold: assert property (p_hold) else $error("sdo moved without sclk");
    property p_por; $fell(srst) |-> !wake_oe_n && alert_oe_n && sdo_oe_n; endproperty
    a_por: assert property (p_por) else $error("bad state after reset");
    property p_alert; $changed(ground_only_inputs) && !wake_oe_n |-> ##[1:8] !alert_oe_n;
    endproperty
    a_alert: assert property (p_alert) else $error("alert not raised");
    property p_keep; (cs_n && !alert_oe_n)[*8] |=> !alert_oe_n; endproperty
    a_keep: assert property (p_keep) else $error("alert dropped while idle");
    property p_wpin; wake_oe_n && $fell(wake_n_in) && alert_n_in |-> ##[2:8] !wake_oe_n;
    endproperty
    a_wpin: assert property (p_wpin) else $error("no wake by wake line");
    property p_awake; wake_oe_n && wake_n_in && $fell(alert_n_in) |-> ##[2:8] !wake_oe_n;
    endproperty
    a_awake: assert property (p_awake) else $error("no wake by alert");
    property p_cwake; wake_oe_n && $fell(cs_n) |-> ##[2:8] !wake_oe_n; endproperty
    a_cwake: assert property (p_cwake) else $error("no wake by select");
endmodule
bind smsp_core smsp_props #(.GND_N(GND_N)) i_props (.mclk(mclk), .srst(srst), .cs_n(cs_n),
    .sclk(sclk), .sdo(sdo), .sdo_oe_n(sdo_oe_n), .alert_n_in(alert_n_in),
    .alert_oe_n(alert_oe_n), .wake_n_in(wake_n_in), .wake_oe_n(wake_oe_n),
    .ground_only_inputs(ground_only_inputs));

// File: bench/smsp_host.sv
// host master model of the serial link
// assumes the bench calls its tasks; pins move at falling mclk
`timescale 1ns/100ps
module smsp_host (
    // clock and link
    input  wire logic mclk,
    input  wire logic sdo,
    input  wire logic sdo_oe_n,
    output logic      cs_n,
    output logic      sclk,
    output logic      sdi
);
    // ****
    // framed transfer, sclk parked low outside frames
    // ****
    initial
    begin
        cs_n = 1'b1;
        sclk = 1'b0;
        sdi  = 1'b0;
    end
    task automatic xfer(input logic [23:0] w, input int n, output logic [23:0] r);
        r = 24'h0;
        @(negedge mclk) cs_n = 1'b0;
        repeat (16) @(negedge mclk);
        for (int i = 0; i < n; i++)
        begin
            sclk = 1'b1;
            sdi  = w[23 - (i % 24)];
            repeat (6) @(negedge mclk);
            sclk = 1'b0;
            r    = {r[22:0], sdo_oe_n ? 1'bz : sdo};
            repeat (2) @(negedge mclk);
        end
        repeat (6) @(negedge mclk);
        cs_n = 1'b1;
        sdi  = ~sdi;
        repeat (8) @(negedge mclk);
    endtask
    // deliberate clocking while deselected
    task automatic noise();
        repeat (8)
        begin
            @(negedge mclk) sclk = ~sclk;
            sdi = ~sdi;
        end
    endtask
endmodule

// File: bench/tb_top.sv
// self-checking bench of the switch monitor serial port
// assumes smsp_host on the link; open-drain lines pulled up here
`timescale 1ns/100ps
module tb_top;
    logic        mclk, srst, battery, otemp, wake_ext, alert_ext, lsup;
    logic        cs_n, sclk, sdi, sdo, sdo_oe_n, stale;
    logic        alert_n_out, alert_oe_n, wake_n_out, wake_oe_n;
    logic [7:0]  dual, pol;
    logic [13:0] gnd;
    logic [15:0] seed;
    logic [23:0] rsp, e;
    int          err_count, n_compared;
    wire logic   alert_n_in = alert_oe_n ? alert_ext : alert_n_out;
    wire logic   wake_n_in = wake_oe_n ? wake_ext : wake_n_out;
    smsp_core i_dut (.mclk(mclk), .srst(srst), .battery_supply(battery), .logic_supply(lsup),
        .over_temp(otemp), .dual_polarity_inputs(dual), .ground_only_inputs(gnd),
        .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe_n(sdo_oe_n),
        .alert_n_in(alert_n_in), .alert_n_out(alert_n_out), .alert_oe_n(alert_oe_n),
        .wake_n_in(wake_n_in), .wake_n_out(wake_n_out), .wake_oe_n(wake_oe_n),
        .stale_status(stale));
    smsp_host i_host (.mclk(mclk), .sdo(sdo), .sdo_oe_n(sdo_oe_n), .cs_n(cs_n),
        .sclk(sclk), .sdi(sdi));
    // ****
    // helpers
    // ****
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [21:0] status(input logic [7:0] p);
        return {~(dual ^ p), ~gnd};
    endfunction
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] %0t ns: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // bit 0 always flips so every stir raises the alert
    task automatic stir();
        seed  = lfsr(seed);
        dual  = seed[7:0];
        otemp = seed[8];
        seed  = lfsr(seed);
        gnd   = gnd ^ (seed[13:0] | 14'h1);
    endtask
    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    initial
    begin
        repeat (20000) @(posedge mclk);
        err_count++;
        end_of_test();
    end
    // ****
    // scenarios
    // ****
    initial
    begin
        {srst, battery, wake_ext, alert_ext, lsup} = 5'h1f;
        {otemp, dual, gnd, pol, seed} = {23'h0, 8'hff, 16'h5f55};
        {err_count, n_compared} = 0;
        repeat (16) @(negedge mclk);
        srst = 1'b0;
        repeat (4) @(negedge mclk);
        for (int t = 0; t < 4; t++)
        begin
            stir();
            repeat (20) @(negedge mclk);
            i_host.xfer(24'h0, 24, rsp);
            check(rsp, {1'b1, otemp, status(pol)});
            check(alert_oe_n, 1'b1);
        end
        e = {1'b0, otemp, status(pol)};
        fork
            i_host.xfer(24'h0, 24, rsp);
            begin
                repeat (100) @(negedge mclk);
                gnd = ~gnd;
            end
        join
        check(rsp, e);
        check(alert_oe_n, 1'b0);
        i_host.xfer(24'h0, 24, rsp);
        check(rsp, {1'b1, otemp, status(pol)});
        $display("status tests done");
        i_host.noise();
        pol = seed[15:8];
        i_host.xfer({smsp_pkg::CMD_SETTINGS, 8'h00, pol}, 24, rsp);
        check(rsp, {1'b0, otemp, status(8'hff)});
        i_host.xfer({smsp_pkg::CMD_SETTINGS, 8'h00, ~pol}, 16, rsp);
        i_host.xfer(24'h0, 24, rsp);
        i_host.xfer(24'h0, 24, rsp);
        check(rsp, {1'b0, otemp, status(pol)});
        battery = 1'b0;
        repeat (10) @(negedge mclk);
        battery = 1'b1;
        repeat (10) @(negedge mclk);
        i_host.xfer(24'h0, 24, rsp);
        check(rsp[21:0], status(8'hff));
        e = {seed, seed[15:8]};
        i_host.xfer(e, 48, rsp);
        check(rsp, e);
        $display("settings tests done");
        for (int k = 0; k < 4; k++)
        begin
            i_host.xfer({smsp_pkg::CMD_SLEEP, 16'h0}, 24, rsp);
            check(wake_oe_n, 1'b1);
            wake_ext = (k == 1) || (k == 2);
            alert_ext = (k == 0) || (k == 2);
            lsup = (k != 3);
            if (k == 2)
                i_host.xfer(24'h0, 24, rsp);
            repeat (12) @(negedge mclk);
            check(wake_oe_n, 1'b0);
            check(stale, k == 2);
            {wake_ext, alert_ext, lsup} = 3'h7;
            repeat (12) @(negedge mclk);
        end
        $display("sleep tests done");
        end_of_test();
    end
endmodule
